// *** tbsdh_cfg.sv ***
// telecom drop and add bus master configuration, parity and marker logic
//
// The strobed register port was decided locally.
module tbsdh_cfg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // drop bus pins
  input wire logic [7:0] drop_data_in,
  input wire logic drop_parity_in,
  input wire logic drop_frame_marker,
  input wire logic drop_payload_ind,
  input wire logic drop_v5_ind,
  input wire logic drop_trib_payload_ind,
  // drop side internal timing and pointer processor return path
  input wire logic h4_mf_start,
  input wire logic [7:0] ptrproc_ret_data,
  input wire logic ptrproc_ret_payload,
  input wire logic ptrproc_ret_v5,
  // drop side outputs to internal blocks
  output logic [7:0] ptrproc_data,
  output logic ptrproc_en,
  output logic rx_overhead_en,
  output logic [7:0] rx_switch_data,
  output logic rx_switch_payload,
  output logic rx_switch_v5,
  output logic rx_switch_trib_payload,
  output logic rx_switch_xc_en,
  output logic drop_au4_mode,
  output logic drop_j1_pulse,
  output logic drop_v1_pulse,
  output logic drop_mf_boundary,
  // add side internal source and timing
  input wire logic [7:0] add_src_data,
  input wire logic add_src_payload,
  input wire logic add_src_v5,
  input wire logic add_c1_slot,
  input wire logic add_j1_slot,
  input wire logic add_toh_slot,
  input wire logic [1:0] add_toh_stm1,
  // add bus pins
  output logic [7:0] add_data_out,
  output logic add_parity_out,
  output logic add_payload_ind,
  output logic add_v5_ind,
  output logic add_frame_marker,
  output logic add_bus_oe,
  // add side controls to internal blocks
  output logic tx_mapper_xc_en,
  output logic add_au4_mode,
  // interrupt
  output logic irq_n
);

  // configuration registers and status bits
  logic [7:0] ing_cfg;
  logic [7:0] egr_cfg;
  logic [7:0] bus_cfg;
  logic drop_parity_err_flag;
  logic sdh_summary_int;

  // drop bus sample stage
  logic [7:0] drop_data_q;
  logic drop_parity_q;
  logic drop_marker_q;
  logic drop_payload_q;
  logic drop_v5_q;
  logic drop_tpl_q;
  logic [2:0] drop_byte_cnt;

  // add side timing state
  logic [2:0] j1_dly;
  logic [1:0] mf_phase;
  tbsdh_pkg::tbsdh_stretch_e stretch_st;
  tbsdh_pkg::tbsdh_stretch_e next_stretch_st;

  // combinational terms
  logic drop_par_err;
  logic drop_is_v1;
  logic par_clr;
  logic wr_ing;
  logic wr_egr;
  logic wr_bus;
  logic wr_stat;
  logic [7:0] next_rdata;
  logic add_j1_mark;
  logic add_v1_slot;
  logic next_marker;
  logic toh_float;
  logic j1_float;
  logic v1_float;
  logic next_oe;
  logic next_parity;

  // parity of a byte with optional marker and payload members
  function automatic logic par_set(input logic [7:0] data, input logic mk, input logic mk_incl,
                                   input logic pl, input logic pl_incl);
    par_set = (^data) ^ (mk & mk_incl) ^ (pl & pl_incl);
  endfunction : par_set

  // register write decode
  assign wr_ing = reg_wr && (reg_addr == tbsdh_pkg::OFS_INGRESS_CFG);
  assign wr_egr = reg_wr && (reg_addr == tbsdh_pkg::OFS_EGRESS_CFG);
  assign wr_bus = reg_wr && (reg_addr == tbsdh_pkg::OFS_BUS_CFG);
  assign wr_stat = reg_wr && (reg_addr == tbsdh_pkg::OFS_STATUS);
  assign par_clr = wr_stat && reg_wdata[tbsdh_pkg::STAT_PAR_ERR];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ing_cfg <= tbsdh_pkg::RST_INGRESS_CFG;
    end else if (wr_ing) begin
      ing_cfg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      egr_cfg <= tbsdh_pkg::RST_EGRESS_CFG;
    end else if (wr_egr) begin
      egr_cfg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_cfg <= tbsdh_pkg::RST_BUS_CFG;
    end else if (wr_bus) begin
      bus_cfg <= reg_wdata;
    end
  end

  // register read, data one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      tbsdh_pkg::OFS_INGRESS_CFG: begin
        next_rdata = ing_cfg;
      end
      tbsdh_pkg::OFS_EGRESS_CFG: begin
        next_rdata = egr_cfg;
      end
      tbsdh_pkg::OFS_BUS_CFG: begin
        next_rdata = {4'h0, bus_cfg[3:0]};
      end
      tbsdh_pkg::OFS_STATUS: begin
        next_rdata = {6'h00, sdh_summary_int, drop_parity_err_flag};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // drop bus sample stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_data_q <= 8'h00;
      drop_parity_q <= 1'b0;
      drop_marker_q <= 1'b0;
      drop_payload_q <= 1'b0;
      drop_v5_q <= 1'b0;
      drop_tpl_q <= 1'b0;
    end else begin
      drop_data_q <= drop_data_in;
      drop_parity_q <= drop_parity_in;
      drop_marker_q <= drop_frame_marker;
      drop_payload_q <= drop_payload_ind;
      drop_v5_q <= drop_v5_ind;
      drop_tpl_q <= drop_trib_payload_ind;
    end
  end

  // drop parity check against the selected sense
  assign drop_par_err = (par_set(drop_data_q, drop_marker_q, ing_cfg[tbsdh_pkg::ING_MARKER_INCL],
                                 drop_payload_q, ing_cfg[tbsdh_pkg::ING_PAYLOAD_INCL])
                         ^ drop_parity_q) != ing_cfg[tbsdh_pkg::ING_PAR_SENSE];

  // sticky error flag, a new error wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_parity_err_flag <= 1'b0;
    end else if (drop_par_err) begin
      drop_parity_err_flag <= 1'b1;
    end else if (par_clr) begin
      drop_parity_err_flag <= 1'b0;
    end
  end

  // summary bit and interrupt follow the enabled flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdh_summary_int <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      sdh_summary_int <= drop_parity_err_flag && ing_cfg[tbsdh_pkg::ING_PAR_INT_EN];
      irq_n <= !(drop_parity_err_flag && ing_cfg[tbsdh_pkg::ING_PAR_INT_EN]);
    end
  end

  // bytes since the last drop marker, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_byte_cnt <= 3'h7;
    end else if (drop_marker_q) begin
      drop_byte_cnt <= 3'h1;
    end else if (drop_byte_cnt != 3'h7) begin
      drop_byte_cnt <= drop_byte_cnt + 3'h1;
    end
  end

  // a marker three bytes after the previous one is a v1 pulse when v1 pulses are in use
  assign drop_is_v1 = drop_marker_q && ing_cfg[tbsdh_pkg::ING_MF_EN]
                      && (drop_byte_cnt == tbsdh_pkg::V1_BYTE_OFFSET);

  // drop marker interpretation
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_au4_mode <= 1'b0;
      drop_j1_pulse <= 1'b0;
      drop_v1_pulse <= 1'b0;
      drop_mf_boundary <= 1'b0;
    end else begin
      drop_au4_mode <= ing_cfg[tbsdh_pkg::ING_CONCAT];
      drop_j1_pulse <= drop_marker_q && !drop_is_v1;
      drop_v1_pulse <= drop_is_v1;
      drop_mf_boundary <= ing_cfg[tbsdh_pkg::ING_MF_EN] ? drop_is_v1 : h4_mf_start;
    end
  end

  // drop data routing around the pointer and overhead processors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptrproc_data <= 8'h00;
      ptrproc_en <= 1'b0;
      rx_overhead_en <= 1'b0;
      rx_switch_data <= 8'h00;
      rx_switch_payload <= 1'b0;
      rx_switch_v5 <= 1'b0;
      rx_switch_trib_payload <= 1'b0;
      rx_switch_xc_en <= 1'b0;
    end else begin
      ptrproc_data <= drop_data_q;
      ptrproc_en <= !ing_cfg[tbsdh_pkg::ING_BYPASS];
      rx_overhead_en <= !ing_cfg[tbsdh_pkg::ING_BYPASS];
      rx_switch_xc_en <= ing_cfg[tbsdh_pkg::ING_TSWITCH_EN];
      if (ing_cfg[tbsdh_pkg::ING_BYPASS]) begin
        rx_switch_data <= drop_data_q;
        rx_switch_payload <= drop_payload_q;
        rx_switch_v5 <= drop_v5_q;
        rx_switch_trib_payload <= drop_tpl_q;
      end else begin
        rx_switch_data <= ptrproc_ret_data;
        rx_switch_payload <= ptrproc_ret_payload;
        rx_switch_v5 <= ptrproc_ret_v5;
        rx_switch_trib_payload <= 1'b0;
      end
    end
  end

  // add side j1 delay line locates the third byte after j1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      j1_dly <= 3'h0;
    end else begin
      j1_dly <= {j1_dly[1:0], add_j1_slot};
    end
  end

  // frame phase within the four frame multiframe, stepped by c1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mf_phase <= 2'h0;
    end else if (add_c1_slot) begin
      mf_phase <= (mf_phase == tbsdh_pkg::MF_LAST_FRAME) ? 2'h0 : mf_phase + 2'h1;
    end
  end

  // au4 j1 stretch across tug3 1, 2 and 3
  always_comb begin
    next_stretch_st = tbsdh_pkg::ST_IDLE;
    case (stretch_st)
      tbsdh_pkg::ST_IDLE: begin
        next_stretch_st = (add_j1_slot && egr_cfg[tbsdh_pkg::EGR_CONCAT]) ? tbsdh_pkg::ST_TUG2
                                                                           : tbsdh_pkg::ST_IDLE;
      end
      tbsdh_pkg::ST_TUG2: begin
        next_stretch_st = tbsdh_pkg::ST_TUG3;
      end
      tbsdh_pkg::ST_TUG3: begin
        next_stretch_st = tbsdh_pkg::ST_IDLE;
      end
      default: begin
        next_stretch_st = tbsdh_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_st <= tbsdh_pkg::ST_IDLE;
    end else begin
      stretch_st <= next_stretch_st;
    end
  end

  // marker composition
  assign add_j1_mark = add_j1_slot || (stretch_st != tbsdh_pkg::ST_IDLE);
  assign add_v1_slot = j1_dly[2] && (mf_phase == tbsdh_pkg::MF_MARK_PHASE);
  assign next_marker = add_c1_slot
                       || (egr_cfg[tbsdh_pkg::EGR_J1_EN] && add_j1_mark)
                       || (egr_cfg[tbsdh_pkg::EGR_V1_EN] && add_v1_slot);

  // float conditions, all overridden by the bus drive enable
  assign j1_float = add_j1_mark && !egr_cfg[tbsdh_pkg::EGR_J1_EN];
  assign v1_float = add_v1_slot && !egr_cfg[tbsdh_pkg::EGR_V1_EN];
  assign toh_float = add_toh_slot && (!egr_cfg[tbsdh_pkg::EGR_TOH_EN]
                     || (bus_cfg[tbsdh_pkg::BUS_FAST_RATE]
                         && (add_toh_stm1 != bus_cfg[tbsdh_pkg::BUS_STM1_MSB:tbsdh_pkg::BUS_STM1_LSB])));
  assign next_oe = bus_cfg[tbsdh_pkg::BUS_DRIVE_EN] || !(j1_float || v1_float || toh_float);

  // generated parity, total over the set and the parity bit equals the sense
  assign next_parity = par_set(add_src_data, next_marker, egr_cfg[tbsdh_pkg::EGR_MARKER_INCL],
                               add_src_payload, egr_cfg[tbsdh_pkg::EGR_PAYLOAD_INCL])
                       ^ egr_cfg[tbsdh_pkg::EGR_PAR_SENSE];

  // add bus output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      add_data_out <= 8'h00;
      add_parity_out <= 1'b0;
      add_payload_ind <= 1'b0;
      add_v5_ind <= 1'b0;
      add_frame_marker <= 1'b0;
      add_bus_oe <= 1'b0;
    end else begin
      add_data_out <= add_src_data;
      add_parity_out <= next_parity;
      add_payload_ind <= add_src_payload;
      add_v5_ind <= add_src_v5;
      add_frame_marker <= next_marker;
      add_bus_oe <= next_oe;
    end
  end

  // egress controls to the mapper side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_mapper_xc_en <= 1'b0;
      add_au4_mode <= 1'b0;
    end else begin
      tx_mapper_xc_en <= egr_cfg[tbsdh_pkg::EGR_TSWITCH_EN];
      add_au4_mode <= egr_cfg[tbsdh_pkg::EGR_CONCAT];
    end
  end

endmodule : tbsdh_cfg

// *** tbsdh_pkg.sv ***
// constants, field layouts and types of the telecom bus master configuration block
package tbsdh_pkg;

  // register port geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [11:0] OFS_INGRESS_CFG = 12'h701;
  localparam logic [11:0] OFS_EGRESS_CFG = 12'h702;
  localparam logic [11:0] OFS_BUS_CFG = 12'h710;
  localparam logic [11:0] OFS_STATUS = 12'h711;

  // reset values
  localparam logic [7:0] RST_INGRESS_CFG = 8'h00;
  localparam logic [7:0] RST_EGRESS_CFG = 8'h00;
  localparam logic [7:0] RST_BUS_CFG = 8'h00;

  // ingress configuration fields
  localparam int ING_CONCAT = 0;
  localparam int ING_PAR_SENSE = 1;
  localparam int ING_MARKER_INCL = 2;
  localparam int ING_PAYLOAD_INCL = 3;
  localparam int ING_TSWITCH_EN = 4;
  localparam int ING_BYPASS = 5;
  localparam int ING_MF_EN = 6;
  localparam int ING_PAR_INT_EN = 7;

  // egress configuration fields
  localparam int EGR_CONCAT = 0;
  localparam int EGR_PAR_SENSE = 1;
  localparam int EGR_MARKER_INCL = 2;
  localparam int EGR_PAYLOAD_INCL = 3;
  localparam int EGR_V1_EN = 4;
  localparam int EGR_J1_EN = 5;
  localparam int EGR_TSWITCH_EN = 6;
  localparam int EGR_TOH_EN = 7;

  // bus configuration fields
  localparam int BUS_DRIVE_EN = 0;
  localparam int BUS_FAST_RATE = 1;
  localparam int BUS_STM1_LSB = 2;
  localparam int BUS_STM1_MSB = 3;

  // status fields
  localparam int STAT_PAR_ERR = 0;
  localparam int STAT_SUMMARY = 1;

  // frame timing counts in bus bytes and frames
  localparam logic [2:0] V1_BYTE_OFFSET = 3'h3;
  localparam logic [1:0] MF_LAST_FRAME = 2'h3;
  localparam logic [1:0] MF_MARK_PHASE = 2'h0;

  // j1 stretch over the three tug3 slots in au4 mode, gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TUG2 = 2'b01,
    ST_TUG3 = 2'b11
  } tbsdh_stretch_e;

endpackage : tbsdh_pkg

// *** tbsdh_cfg_assertions.sv ***
// port assertions for the telecom bus configuration block
module tbsdh_cfg_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // drop bus
  input wire logic [7:0] drop_data_in,
  input wire logic drop_parity_in,
  input wire logic drop_frame_marker,
  input wire logic drop_payload_ind,
  // add side
  input wire logic add_c1_slot,
  input wire logic add_j1_slot,
  input wire logic add_toh_slot,
  input wire logic [7:0] add_data_out,
  input wire logic add_parity_out,
  input wire logic add_payload_ind,
  input wire logic add_frame_marker,
  input wire logic add_bus_oe,
  input wire logic irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ing;
  logic [7:0] egr;
  logic [3:0] bus;
  logic bad;
  // shadow copies of the configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ing <= 8'h00;
      egr <= 8'h00;
      bus <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        tbsdh_pkg::OFS_INGRESS_CFG: ing <= reg_wdata;
        tbsdh_pkg::OFS_EGRESS_CFG: egr <= reg_wdata;
        tbsdh_pkg::OFS_BUS_CFG: bus <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end
  assign bad = (^drop_data_in ^ (drop_frame_marker & ing[2]) ^ (drop_payload_ind & ing[3]) ^ drop_parity_in) != ing[1];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence err_held_s;
    bad && ing[7] ##1 $stable(ing) [*2];
  endsequence
  sequence stretch_s;
    add_frame_marker [*3];
  endsequence
  cfg_readback_a: assert property (reg_rd && reg_addr == tbsdh_pkg::OFS_INGRESS_CFG |=> reg_rdata == $past(ing))
    else $error("ingress config readback wrong");
  irq_quiet_a: assert property (!ing[7] && !$past(ing[7]) |-> irq_n)
    else $error("interrupt while disabled");
  irq_raise_a: assert property (err_held_s |=> !irq_n)
    else $error("parity error did not raise interrupt");
  add_parity_a: assert property ((^add_data_out ^ (add_frame_marker & $past(egr[2]))
    ^ (add_payload_ind & $past(egr[3])) ^ add_parity_out) == $past(egr[1])) else $error("add parity wrong");
  c1_mark_a: assert property (add_c1_slot |=> add_frame_marker)
    else $error("c1 not marked");
  j1_stretch_a: assert property (add_j1_slot && egr[5] && egr[0] |=> stretch_s)
    else $error("au4 j1 not stretched");
  j1_float_a: assert property (add_j1_slot && !egr[5] && !bus[0] |=> !add_bus_oe)
    else $error("add bus driven in unmarked j1");
  drive_override_a: assert property (bus[0] |=> add_bus_oe)
    else $error("drive enable not honoured");
  toh_float_a: assert property (add_toh_slot && !egr[7] && !bus[0] |=> !add_bus_oe)
    else $error("add bus driven in overhead");
  toh_drive_a: assert property (add_toh_slot && egr[7] && egr[5] && egr[4] && !bus[1] |=> add_bus_oe)
    else $error("add bus not driven in overhead");
endmodule : tbsdh_cfg_assertions

bind tbsdh_cfg tbsdh_cfg_assertions u_tbsdh_cfg_assertions (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .drop_data_in, .drop_parity_in, .drop_frame_marker, .drop_payload_ind, .add_c1_slot, .add_j1_slot,
  .add_toh_slot, .add_data_out, .add_parity_out, .add_payload_ind, .add_frame_marker, .add_bus_oe, .irq_n);

// *** tbsdh_framer_model.sv ***
// far side framer model driving a continuous drop bus
module tbsdh_framer_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // parity setup and fault command
  input wire logic sense,
  input wire logic mark_incl,
  input wire logic pay_incl,
  input wire logic corrupt,
  input wire logic extra_mark,
  // drop bus
  output logic [7:0] data,
  output logic parity,
  output logic marker,
  output logic payload,
  output logic v5,
  output logic trib_payload
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic [7:0] next_data;
  logic next_marker;
  logic next_payload;
  assign next_data = cnt ^ {cnt[3:0], cnt[7:4]} ^ 8'h5A;
  assign next_marker = (cnt[3:0] == 4'h0) || extra_mark;
  assign next_payload = cnt[2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      data <= 8'h00;
      parity <= 1'b0;
      marker <= 1'b0;
      payload <= 1'b0;
      v5 <= 1'b0;
      trib_payload <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      data <= next_data;
      marker <= next_marker;
      payload <= next_payload;
      v5 <= cnt[5:0] == 6'h03;
      trib_payload <= next_payload;
      parity <= sense ^ corrupt ^ (^next_data) ^ (next_marker & mark_incl) ^ (next_payload & pay_incl);
    end
  end
endmodule : tbsdh_framer_model

// *** tb_top.sv ***
// self-checking bench for the telecom bus configuration block
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] egr;
    logic [7:0] bus;
    logic [2:0] s;
    logic [1:0] st;
    logic [2:0] mk;
    logic oe;
  } tbsdh_row_s;
  tbsdh_row_s rows [9] = '{'{8'h00, 8'h00, 3'h2, 2'h0, 3'h0, 1'h0}, '{8'h2E, 8'h00, 3'h2, 2'h0, 3'h4, 1'h1},
    '{8'h21, 8'h00, 3'h2, 2'h0, 3'h7, 1'h1}, '{8'h00, 8'h01, 3'h2, 2'h0, 3'h0, 1'h1},
    '{8'hB0, 8'h00, 3'h1, 2'h0, 3'h0, 1'h1}, '{8'h30, 8'h00, 3'h1, 2'h0, 3'h0, 1'h0},
    '{8'hB0, 8'h02, 3'h1, 2'h1, 3'h0, 1'h0}, '{8'hB0, 8'h0A, 3'h1, 2'h2, 3'h0, 1'h1},
    '{8'h0C, 8'h00, 3'h4, 2'h0, 3'h4, 1'h1}};
  logic [11:0] ra [4] = '{12'h701, 12'h702, 12'h710, 12'h7FF};
  logic [7:0] rw [4] = '{8'hA1, 8'h5A, 8'hFF, 8'hFF};
  logic [7:0] re [4] = '{8'hA1, 8'h5A, 8'h0F, 8'h00};
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, add_c1_slot = 1'b0, add_j1_slot = 1'b0;
  logic add_toh_slot = 1'b0, add_src_payload = 1'b0, sense = 1'b0, mincl = 1'b0, pincl = 1'b0, corrupt = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00, add_src_data = 8'h00, reg_rdata, drop_data_in, add_data_out, rv, cfg, d0;
  logic [1:0] add_toh_stm1 = 2'h0;
  logic drop_parity_in, drop_frame_marker, drop_payload_ind, drop_v5_ind, drop_trib_payload_ind;
  logic add_parity_out, add_payload_ind, add_v5_ind, add_frame_marker, add_bus_oe, irq_n, p0, pl0;
  logic [7:0] ptrproc_ret_data = 8'h00, ptrproc_data, rx_switch_data;
  logic h4_mf_start = 1'b0, xmark = 1'b0, v50, ptrproc_en, rx_overhead_en, rx_switch_payload, rx_switch_v5;
  logic rx_switch_trib_payload, rx_switch_xc_en, drop_au4_mode, drop_j1_pulse, drop_v1_pulse, drop_mf_boundary;
  logic tx_mapper_xc_en, add_au4_mode;
  logic mk [5];
  logic oe [5];
  int n_mismatch = 0, checked = 0, ph = 0;
  always #5 clk = ~clk;
  tbsdh_framer_model u_tbsdh_framer_model (.clk, .rst_n, .sense, .mark_incl(mincl), .pay_incl(pincl), .corrupt,
    .data(drop_data_in), .parity(drop_parity_in), .marker(drop_frame_marker), .payload(drop_payload_ind),
    .v5(drop_v5_ind), .trib_payload(drop_trib_payload_ind), .extra_mark(xmark));
  tbsdh_cfg u_tbsdh_cfg (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .drop_data_in,
    .drop_parity_in, .drop_frame_marker, .drop_payload_ind, .drop_v5_ind, .drop_trib_payload_ind,
    .h4_mf_start, .ptrproc_ret_data, .ptrproc_ret_payload(ptrproc_ret_data[0]),
    .ptrproc_ret_v5(ptrproc_ret_data[1]),
    .ptrproc_data, .ptrproc_en, .rx_overhead_en, .rx_switch_data, .rx_switch_payload, .rx_switch_v5,
    .rx_switch_trib_payload, .rx_switch_xc_en, .drop_au4_mode, .drop_j1_pulse, .drop_v1_pulse,
    .drop_mf_boundary, .add_src_data, .add_src_payload, .add_src_v5(add_src_data[1]), .add_c1_slot, .add_j1_slot,
    .add_toh_slot, .add_toh_stm1, .add_data_out, .add_parity_out, .add_payload_ind, .add_v5_ind, .add_frame_marker,
    .add_bus_oe, .tx_mapper_xc_en, .add_au4_mode, .irq_n);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    `CHK("register read", e, rv)
  endtask : rchk
  task automatic bad_byte();
    @(posedge clk);
    corrupt <= 1'b1;
    @(posedge clk);
    corrupt <= 1'b0;
    cyc(4);
  endtask : bad_byte
  task automatic slots(input logic [2:0] s, input logic [1:0] st, input logic [7:0] d);
    @(posedge clk);
    {add_c1_slot, add_j1_slot, add_toh_slot} <= s;
    add_toh_stm1 <= st;
    add_src_data <= d;
    add_src_payload <= d[0];
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {add_c1_slot, add_j1_slot, add_toh_slot} <= 3'h0;
      #1;
      mk[i] = add_frame_marker;
      oe[i] = add_bus_oe;
      if (i == 0) {d0, pl0, p0, v50} = {add_data_out, add_payload_ind, add_parity_out, add_v5_ind};
    end
  endtask : slots
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    cyc(60000);
    n_mismatch++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    `CHK("irq after reset", 1'b1, irq_n)
    rchk(tbsdh_pkg::OFS_INGRESS_CFG, 8'h00);
    rchk(tbsdh_pkg::OFS_EGRESS_CFG, 8'h00);
    foreach (ra[i]) begin
      wr(ra[i], rw[i]);
      rchk(ra[i], re[i]);
    end
    foreach (rows[i]) begin
      wr(tbsdh_pkg::OFS_EGRESS_CFG, rows[i].egr);
      wr(tbsdh_pkg::OFS_BUS_CFG, rows[i].bus);
      cfg = 8'(i * 8'h37);
      slots(rows[i].s, rows[i].st, cfg);
      `CHK("add marker", rows[i].mk, {mk[0], mk[1], mk[2]})
      `CHK("add drive", rows[i].oe, oe[0])
      `CHK("add data", cfg, d0)
      `CHK("add payload", cfg[0], pl0)
      `CHK("add v5", cfg[1], v50)
      `CHK("add parity", ^d0 ^ (mk[0] & rows[i].egr[2]) ^ (pl0 & rows[i].egr[3]) ^ rows[i].egr[1], p0)
    end
    ph = 1;
    wr(tbsdh_pkg::OFS_BUS_CFG, 8'h00);
    for (int f = 0; f < 8; f++) begin
      wr(tbsdh_pkg::OFS_EGRESS_CFG, f < 4 ? 8'h30 : 8'h20);
      slots(3'h2, 2'h0, 8'h3C);
      `CHK("v1 marker", ph == 0 && f < 4, mk[3])
      `CHK("v1 drive", !(ph == 0 && f >= 4), oe[3])
      slots(3'h4, 2'h0, 8'hC3);
      ph = (ph + 1) % 4;
    end
    for (int c = 0; c < 8; c++) begin
      cfg = 8'(c * 2);
      wr(tbsdh_pkg::OFS_INGRESS_CFG, cfg);
      {pincl, mincl, sense} <= cfg[3:1];
      cyc(4);
      wr(tbsdh_pkg::OFS_STATUS, 8'h01);
      cyc(16);
      rchk(tbsdh_pkg::OFS_STATUS, 8'h00);
      bad_byte();
      rchk(tbsdh_pkg::OFS_STATUS, 8'h01);
      `CHK("irq masked", 1'b1, irq_n)
      wr(tbsdh_pkg::OFS_INGRESS_CFG, cfg | 8'h80);
      cyc(3);
      `CHK("irq enabled", 1'b0, irq_n)
      rchk(tbsdh_pkg::OFS_STATUS, 8'h03);
      wr(tbsdh_pkg::OFS_STATUS, 8'h01);
      cyc(3);
      `CHK("irq cleared", 1'b1, irq_n)
      bad_byte();
      `CHK("irq raised", 1'b0, irq_n)
    end
    wr(tbsdh_pkg::OFS_INGRESS_CFG, 8'h51);
    wr(tbsdh_pkg::OFS_EGRESS_CFG, 8'h41);
    ptrproc_ret_data <= 8'h96;
    cyc(2);
    `CHK("drop au4", 1'b1, drop_au4_mode)
    `CHK("rx xc", 1'b1, rx_switch_xc_en)
    `CHK("ptrproc en", 2'h3, {ptrproc_en, rx_overhead_en})
    `CHK("tx xc", 2'h3, {tx_mapper_xc_en, add_au4_mode})
    `CHK("rx path data", 8'h96, rx_switch_data)
    `CHK("rx path ind", 3'h2, {rx_switch_payload, rx_switch_v5, rx_switch_trib_payload})
    d0 = drop_data_in;
    cyc(2);
    `CHK("ptrproc data", d0, ptrproc_data)
    for (int k = 0; k < 20 && drop_frame_marker !== 1'b1; k++) cyc(1);
    `CHK("marker seen", 1'b1, drop_frame_marker)
    cyc(2);
    `CHK("j1 pulse", 1'b1, drop_j1_pulse)
    xmark <= 1'b1;
    cyc(1);
    xmark <= 1'b0;
    cyc(2);
    `CHK("v1 pulse", 3'h3, {drop_j1_pulse, drop_v1_pulse, drop_mf_boundary})
    h4_mf_start <= 1'b1;
    cyc(1);
    h4_mf_start <= 1'b0;
    `CHK("h4 ignored", 1'b0, drop_mf_boundary)
    wr(tbsdh_pkg::OFS_INGRESS_CFG, 8'h20);
    h4_mf_start <= 1'b1;
    cyc(1);
    h4_mf_start <= 1'b0;
    `CHK("h4 boundary", 1'b1, drop_mf_boundary)
    `CHK("bypass en", 2'h0, {ptrproc_en, rx_overhead_en})
    {rv, pl0, p0, v50} = {drop_data_in, drop_payload_ind, drop_v5_ind, drop_trib_payload_ind};
    cyc(2);
    `CHK("rx bypass data", rv, rx_switch_data)
    `CHK("rx bypass ind", {pl0, p0, v50}, {rx_switch_payload, rx_switch_v5, rx_switch_trib_payload})
    results();
  end
endmodule : tb_top
